// [phy_mgmt_pkg.sv]
/*
 * Shared constants for the management serial port: frame field codes,
 * register indexes, field positions, reset values and the frame state type.
 * Assumes a single clock domain at the block (mclk) with the management
 * clock arriving as a sampled pin.
 */
package phy_mgmt_pkg;
    // Frame layout
    localparam logic [5:0] PRE_MIN = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0B;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    // Register indexes within each channel
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_IMASK = 5'h10;
    localparam logic [4:0] REG_ISTAT = 5'h11;
    // Field positions
    localparam int CTRL_FIBER_BIT = 0;
    localparam int STAT_LINK_BIT = 0;
    localparam int STAT_SD_BIT = 1;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IMASK_RST = 16'h0000;
    localparam logic [1:0] ISTAT_RST = 2'h0;
    typedef enum {ST_IDLE, ST_START, ST_HDR, ST_TA, ST_RDATA, ST_WDATA} frame_state_t;
endpackage : phy_mgmt_pkg

// [phy_mgmt_serial_port.sv]
/*
 * Management serial port of a multi-channel transceiver: a frame slave
 * on the management clock/data pins, per-channel control, status and
 * change-interrupt registers, and the maskable status interrupt pin.
 * Assumes the management clock and data and the signal-detect pins are
 * asynchronous to mclk; mclk must run well above four times the
 * management clock rate.
 */
// Overview of operation
// - Device drives read data synchronous to management clock
// - Management clock unrelated to data-path clocks
// - Interrupt pin high on any monitored status change whose mask bit is set
// - Signal-detect ignored on non-fiber channels
`timescale 1ns/1ps
module phy_mgmt_serial_port
    import phy_mgmt_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter logic [4:0] PHY_BASE = 5'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Channel status and fiber pins
    input wire logic [NUM_CH-1:0] link_up,
    input wire logic [NUM_CH-1:0] fiber_signal_detect,
    output logic [NUM_CH-1:0] fiber_mode,
    // Interrupt
    output logic mask_stat_int
);
    localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    logic [2:0] mdc_s_r;
    logic [2:0] mdio_s_r;
    logic mdc_lvl_r;
    frame_state_t state_r;
    logic [5:0] cnt_r;
    logic [11:0] hdr_r;
    logic [15:0] data_r;
    logic out_r;
    logic oe_r;
    logic int_r;
    logic [15:0] rd_word [NUM_CH];
    logic [1:0] pend [NUM_CH];
    logic [NUM_CH-1:0] hit_any;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mdc_s_r <= 3'h0;
            mdio_s_r <= 3'h7;
            mdc_lvl_r <= 1'b0;
        end else begin
            mdc_s_r <= {mdc_s_r[1:0], mdc};
            mdio_s_r <= {mdio_s_r[1:0], mdio_in};
            if (mdc_s_r[1] == mdc_s_r[2]) begin
                mdc_lvl_r <= mdc_s_r[2];
            end
        end
    end

    wire mdc_rise = mdc_s_r[1] & mdc_s_r[2] & ~mdc_lvl_r;
    wire bit_in = mdio_s_r[2];
    wire [11:0] hdr_full = {hdr_r[10:0], bit_in};
    wire [1:0] op_f = hdr_full[11:10];
    wire [4:0] ch_off_f = hdr_full[9:5] - PHY_BASE;
    wire ch_ok_f = ch_off_f < 5'(NUM_CH);
    wire [CHW-1:0] ch_f = ch_off_f[CHW-1:0];
    wire [4:0] reg_f = hdr_full[4:0];
    wire hdr_done = mdc_rise && state_r == ST_HDR && cnt_r == {1'b0, HDR_LAST};
    wire rd_start = hdr_done && op_f == OP_READ && ch_ok_f;
    wire is_read = hdr_r[11:10] == OP_READ && (hdr_r[9:5] - PHY_BASE) < 5'(NUM_CH);
    wire is_write = hdr_r[11:10] == OP_WRITE && (hdr_r[9:5] - PHY_BASE) < 5'(NUM_CH);
    wire wr_go = mdc_rise && state_r == ST_WDATA && cnt_r == {1'b0, DATA_LAST};
    wire [15:0] wr_word = {data_r[14:0], bit_in};
    wire [4:0] wr_off = hdr_r[9:5] - PHY_BASE;
    wire [CHW-1:0] wr_ch = wr_off[CHW-1:0];
    wire [4:0] wr_reg = hdr_r[4:0];

    // Frame sequencer, advances only on management clock edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cnt_r <= 6'h00;
            hdr_r <= 12'h000;
            data_r <= 16'h0000;
            out_r <= 1'b1;
            oe_r <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (bit_in) begin
                        cnt_r <= (cnt_r < PRE_MIN) ? cnt_r + 6'h01 : cnt_r;
                    end else begin
                        state_r <= (cnt_r >= PRE_MIN) ? ST_START : ST_IDLE;
                        cnt_r <= 6'h00;
                    end
                end
                ST_START: begin
                    state_r <= bit_in ? ST_HDR : ST_IDLE;
                end
                ST_HDR: begin
                    hdr_r <= hdr_full;
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == {1'b0, HDR_LAST}) begin
                        state_r <= ST_TA;
                        cnt_r <= 6'h00;
                        data_r <= rd_start ? rd_word[ch_f] : 16'h0000;
                    end
                end
                ST_TA: begin
                    cnt_r <= 6'h01;
                    if (cnt_r == 6'h00) begin
                        // Drive turnaround zero on second bit
                        if (is_read) begin
                            oe_r <= 1'b1;
                            out_r <= 1'b0;
                        end
                    end else begin
                        cnt_r <= 6'h00;
                        if (is_read) begin
                            state_r <= ST_RDATA;
                            out_r <= data_r[15];
                            data_r <= {data_r[14:0], 1'b0};
                        end else begin
                            state_r <= is_write ? ST_WDATA : ST_IDLE;
                        end
                    end
                end
                ST_RDATA: begin
                    // Shift read data out per clock
                    if (cnt_r == {1'b0, DATA_LAST}) begin
                        oe_r <= 1'b0;
                        out_r <= 1'b1;
                        state_r <= ST_IDLE;
                        cnt_r <= 6'h00;
                    end else begin
                        out_r <= data_r[15];
                        data_r <= {data_r[14:0], 1'b0};
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                ST_WDATA: begin
                    data_r <= wr_word;
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == {1'b0, DATA_LAST}) begin
                        state_r <= ST_IDLE;
                        cnt_r <= 6'h00;
                    end
                end
            endcase
        end
    end

    assign mdio_out = out_r;
    assign mdio_oe = oe_r;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [2:0] sd_s_r;
            logic sd_lvl_r;
            logic [15:0] ctrl_r;
            logic [15:0] imask_r;
            logic [1:0] istat_r;
            logic [1:0] prev_r;
            wire sel_wr = wr_go && wr_ch == CHW'(g);
            wire rd_clr = rd_start && ch_f == CHW'(g) && reg_f == REG_ISTAT;
            wire sd_eff = sd_lvl_r & ctrl_r[CTRL_FIBER_BIT];
            wire [1:0] stat_now = {sd_eff, link_up[g]};
            // No detect event while copper, mode exit included
            wire [1:0] chg = (stat_now ^ prev_r) & {ctrl_r[CTRL_FIBER_BIT], 1'b1};
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    sd_s_r <= 3'h0;
                    sd_lvl_r <= 1'b0;
                    ctrl_r <= CTRL_RST;
                    imask_r <= IMASK_RST;
                    istat_r <= ISTAT_RST;
                    prev_r <= 2'h0;
                end else begin
                    sd_s_r <= {sd_s_r[1:0], fiber_signal_detect[g]};
                    if (sd_s_r[1] == sd_s_r[2]) begin
                        sd_lvl_r <= sd_s_r[2];
                    end
                    if (sel_wr && wr_reg == REG_CTRL) begin
                        ctrl_r <= wr_word;
                    end
                    if (sel_wr && wr_reg == REG_IMASK) begin
                        imask_r <= wr_word;
                    end
                    prev_r <= stat_now;
                    // Change sets sticky bit, set beats read clear
                    istat_r <= (istat_r & {2{~rd_clr}}) | chg;
                end
            end
            assign fiber_mode[g] = ctrl_r[CTRL_FIBER_BIT];
            assign pend[g] = istat_r & imask_r[1:0];
            assign hit_any[g] = |pend[g];
            assign rd_word[g] = (reg_f == REG_CTRL) ? ctrl_r :
                                (reg_f == REG_STAT) ? {14'h0000, stat_now} :
                                (reg_f == REG_IMASK) ? imask_r :
                                (reg_f == REG_ISTAT) ? {14'h0000, istat_r} : 16'h0000;

            property p_sd_ignored;
                @(posedge mclk) disable iff (sys_rst)
                !ctrl_r[CTRL_FIBER_BIT] |-> !stat_now[STAT_SD_BIT] && !istat_r[STAT_SD_BIT] ||
                    $past(ctrl_r[CTRL_FIBER_BIT]) || $past(istat_r[STAT_SD_BIT]);
            endproperty
            a_sd_ignored: assert property (p_sd_ignored) else $error("sd seen off fiber");
        end
    endgenerate

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            int_r <= 1'b0;
        end else begin
            int_r <= |hit_any;
        end
    end
    assign mask_stat_int = int_r;

    property p_out_on_mdc;
        @(posedge mclk) disable iff (sys_rst)
        !$stable(mdio_out) || !$stable(mdio_oe) |-> $past(mdc_rise);
    endproperty
    a_out_on_mdc: assert property (p_out_on_mdc) else $error("mdio moved off edge");

    property p_state_on_mdc;
        @(posedge mclk) disable iff (sys_rst)
        !$stable(state_r) |-> $past(mdc_rise);
    endproperty
    a_state_on_mdc: assert property (p_state_on_mdc) else $error("state moved off edge");

    property p_irq;
        @(posedge mclk) disable iff (sys_rst)
        (|hit_any) |=> mask_stat_int ##0 ($past(|hit_any) == mask_stat_int);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_ta_zero;
        @(posedge mclk) disable iff (sys_rst)
        $rose(mdio_oe) |-> !mdio_out && state_r == ST_TA ##1 mdio_oe [*3];
    endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("bad turnaround");

    property p_oe_states;
        @(posedge mclk) disable iff (sys_rst)
        mdio_oe |-> state_r == ST_TA || state_r == ST_RDATA;
    endproperty
    a_oe_states: assert property (p_oe_states) else $error("drive outside read");
endmodule : phy_mgmt_serial_port

// [mgmt_ctrl_model.sv]
/*
 * Station management controller model: frames on the management clock
 * and data pins, reads and writes one register per frame.
 * Assumes the data wire has a pull-up and the device's enable is high while it drives.
 */
`timescale 1ns/1ps
module mgmt_ctrl_model
    import phy_mgmt_pkg::*;
#(
    // half period in mclk cycles, 160 ns period keeps to the crystal limit
    parameter int HALF = 20
) (
    // Clock
    input wire logic mclk,
    // Device drive
    input wire logic mdio_out,
    input wire logic mdio_oe,
    // Controller pins
    output logic mdc,
    output logic mdio_in
);
    logic drv_r;
    logic drv_oe_r;

    // Released wire is pulled up
    assign mdio_in = mdio_oe ? mdio_out : (drv_oe_r ? drv_r : 1'h1);

    initial begin
        mdc = 1'h0;
        drv_r = 1'h1;
        drv_oe_r = 1'h0;
    end

    // data set while clock low, sampled at the rise
    task automatic send_bit(input logic b, input logic own, output logic smp);
        @(posedge mclk);
        mdc <= 1'h0;
        drv_r <= b;
        drv_oe_r <= own;
        repeat (HALF) @(posedge mclk);
        smp = mdio_in;
        mdc <= 1'h1;
        repeat (HALF - 1) @(posedge mclk);
    endtask : send_bit

    // preamble, start, op, addresses, turnaround, data
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [45:0] hdr;
        logic smp;
        logic wr;
        hdr = {32'hFFFFFFFF, 2'h1, op, phy, regad};
        wr = (op == OP_WRITE);
        rdata = 16'h0000;
        for (int i = 45; i >= 0; i--) begin
            send_bit(hdr[i], 1'h1, smp);
        end
        // Line released through turnaround on reads so the device can take it
        send_bit(1'h1, wr, smp);
        send_bit(1'h0, wr, smp);
        for (int i = 15; i >= 0; i--) begin
            send_bit(wdata[i], wr, smp);
            rdata[i] = smp;
        end
        // Clock stands still low between frames
        @(posedge mclk);
        mdc <= 1'h0;
        drv_oe_r <= 1'h0;
    endtask : frame
endmodule : mgmt_ctrl_model

// [phy_mgmt_serial_port_tb_top.sv]
/*
 * Testbench for the management serial port: register access, fiber
 * signal-detect gating, change interrupt and refused addresses.
 * Assumes the controller model in its own file and the shared package.
 */
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module phy_mgmt_serial_port_tb_top;
    import phy_mgmt_pkg::*;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic mdc;
    logic mdio_in;
    logic mdio_out;
    logic mdio_oe;
    logic [3:0] link_up = 4'h0;
    logic [3:0] fiber_signal_detect = 4'h0;
    logic [3:0] fiber_mode;
    logic mask_stat_int;
    logic [15:0] d;
    int errors = 0;
    int checks = 0;

    always #2 mclk = ~mclk;

    phy_mgmt_serial_port phy_mgmt_serial_port_inst (.mclk(mclk), .sys_rst(sys_rst), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .link_up(link_up),
        .fiber_signal_detect(fiber_signal_detect), .fiber_mode(fiber_mode),
        .mask_stat_int(mask_stat_int));
    mgmt_ctrl_model mgmt_ctrl_model_inst (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_in(mdio_in));

    task automatic rd(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] q);
        mgmt_ctrl_model_inst.frame(OP_READ, phy, ra, 16'h0000, q);
    endtask : rd

    task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] v);
        logic [15:0] q;
        mgmt_ctrl_model_inst.frame(OP_WRITE, phy, ra, v, q);
    endtask : wr

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic wait_int(input logic v);
        for (int i = 0; i < 10 && mask_stat_int !== v; i++) @(posedge mclk);
        `CHK(mask_stat_int, v, "interrupt pin level");
    endtask : wait_int

    task automatic check_reset();
        `CHK({mdio_oe, mdio_out, fiber_mode, mask_stat_int}, 7'h20, "reset outputs");
        rd(5'h00, REG_CTRL, d);
        `CHK(d, CTRL_RST, "control reset value");
        rd(5'h03, REG_IMASK, d);
        `CHK(d, IMASK_RST, "mask reset value");
    endtask : check_reset

    task automatic check_ctrl();
        for (int c = 0; c < 4; c++) wr(5'(c), REG_CTRL, 16'hC3C0 + 16'(c));
        for (int c = 0; c < 4; c++) begin
            rd(5'(c), REG_CTRL, d);
            `CHK(d, 16'hC3C0 + 16'(c), "control readback");
        end
        `CHK(fiber_mode, 4'hA, "fiber mode outputs");
    endtask : check_ctrl

    task automatic check_sd();
        fiber_signal_detect <= 4'hF;
        repeat (8) @(posedge mclk);
        rd(5'h00, REG_STAT, d);
        `CHK(d, 16'h0000, "detect seen on copper channel");
        rd(5'h01, REG_STAT, d);
        `CHK(d, 16'h0002, "detect lost on fiber channel");
        rd(5'h02, REG_ISTAT, d);
        `CHK(d, 16'h0000, "event on copper channel");
        rd(5'h01, REG_ISTAT, d);
        `CHK(d, 16'h0002, "event on fiber channel");
        rd(5'h03, REG_ISTAT, d);
        `CHK(d, 16'h0002, "event on second fiber channel");
        wr(5'h03, REG_CTRL, 16'h0000);
        rd(5'h03, REG_ISTAT, d);
        `CHK(d, 16'h0000, "event after fiber mode left");
    endtask : check_sd

    task automatic check_int();
        wr(5'h02, REG_IMASK, 16'h0001);
        link_up <= 4'h8;
        repeat (10) @(posedge mclk);
        `CHK(mask_stat_int, 1'h0, "masked change raised pin");
        link_up <= 4'hC;
        wait_int(1'h1);
        rd(5'h02, REG_ISTAT, d);
        `CHK(d, 16'h0001, "link change flag");
        wait_int(1'h0);
    endtask : check_int

    task automatic check_refuse();
        rd(5'h04, REG_CTRL, d);
        `CHK(d, 16'hFFFF, "foreign address answered");
    endtask : check_refuse

    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        check_reset();
        check_ctrl();
        check_sd();
        check_int();
        check_refuse();
        complete_run();
    end
endmodule : phy_mgmt_serial_port_tb_top
